//--- design/rtc_control_status_interrupt.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module rtc_control_status_interrupt
   import rtc_pkg::*;
#(
   parameter int unsigned TB_DIV = BASE_DIV
) (
   // clock and bus reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // avalon-mm slave
   input  wire avalon_req_s bus_req,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // power sense and interrupt pins
   input  wire logic        power_sense_in,
   output logic             clock_irq_n
);

   // ==========================================================
   // elaboration checks
   if (TB_DIV < 1 || TB_DIV > 4096) begin : g_bad_div
      $error("TB_DIV must lie in 1..4096");
   end

   localparam logic [PHASE_W-1:0] PHASE_LAST = '1;
   localparam logic [PHASE_W-1:0] UIP_FROM   = PHASE_LAST - PHASE_W'(UIP_LEAD_TICKS);
   localparam logic [11:0]        DIV_LAST   = 12'(TB_DIV - 1);

   // ==========================================================
   // state: reset side and battery side
   typedef struct packed {
      logic               ack;
      logic [7:0]         rdata;
      logic [2:0]         rep;
      logic               upd;
      logic               update_end_irq_enable;
      logic               alarm_irq_enable;
      logic               periodic_irq_enable;
      logic               uf;
      logic               af;
      logic               pf;
      logic               irq;
      logic               update_in_progress;
      logic [11:0]        div;
      logic [PHASE_W-1:0] phase;
   } ctl_s;

   typedef struct packed {
      time_mode_s  mode;
      logic        set;
      logic [3:0]  rate;
      clock_time_s alarm;
      calendar_s   cal;
      logic        ps_meta;
      logic        ps_sync;
      logic        ram_valid;
   } keep_s;

   ctl_s        s;
   ctl_s        next_s;
   keep_s       k;
   keep_s       next_k;
   clock_time_s now;
   logic [3:0]  idx;
   logic [7:0]  wd;
   logic [7:0]  rd_val;
   logic        take;
   logic        done_rd;
   logic        done_wr;
   logic        clr;
   logic        base;
   logic        sec_tick;
   logic        pf_hit;
   logic        alarm_hit;
   logic        kp_wr;

   // ==========================================================
   // helpers
   function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] t);
      return (a[7:6] == ALARM_WILD) || (a == t);
   endfunction

   // rate 1 and 2 reuse the slow taps of 8 and 9
   function automatic logic tap_hit(input logic [3:0] rs, input logic [PHASE_W-1:0] ph);
      logic [3:0]         sh;
      logic [PHASE_W-1:0] m;
      sh = (rs < RS_FAST_MIN) ? rs + RS_SLOW_OFS : rs - 4'h1;
      m  = (PHASE_W'(1) << sh) - PHASE_W'(1);
      return (rs != 4'h0) && ((ph & m) == m);
   endfunction

   // ==========================================================
   // bus handshake: one wait cycle, answer on the second edge
   assign idx         = bus_req.address[5:2];
   assign wd          = bus_req.writedata[7:0];
   assign take        = (bus_req.read | bus_req.write) & ~s.ack;
   assign done_rd     = bus_req.read & s.ack;
   assign done_wr     = bus_req.write & s.ack & bus_req.byteenable[0];
   assign waitrequest = (bus_req.read | bus_req.write) & ~s.ack;
   assign readdata    = {24'h00_0000, s.rdata};
   assign clock_irq_n = ~s.irq;
   assign clr         = done_rd && idx == IDX_FLAG;

   // ==========================================================
   // time base and events
   assign base      = s.div == DIV_LAST;
   assign sec_tick  = base & (s.phase == PHASE_LAST) & ~k.set;
   assign pf_hit    = base & tap_hit(k.rate, s.phase);
   assign alarm_hit = byte_hit(k.alarm.sec, now.sec) & byte_hit(k.alarm.min, now.min)
                    & byte_hit(k.alarm.hour, now.hour);
   assign kp_wr     = done_wr && (idx == IDX_SEC || idx == IDX_MIN || idx == IDX_HOUR);

   rtc_time_keeper u_keeper (
      .clk     (clk),
      .tick    (sec_tick),
      .mode    (k.mode),
      .cal     (k.cal),
      .wr_en   (kp_wr),
      .wr_sel  (idx[2:1]),
      .wr_data (wd),
      .now     (now)
   );

   // ==========================================================
   // read multiplexer, unmapped reads give zero
   always_comb begin
      rd_val = 8'h00;
      if (idx == IDX_SEC) begin
         rd_val = now.sec;
      end else if (idx == IDX_ASEC) begin
         rd_val = k.alarm.sec;
      end else if (idx == IDX_MIN) begin
         rd_val = now.min;
      end else if (idx == IDX_AMIN) begin
         rd_val = k.alarm.min;
      end else if (idx == IDX_HOUR) begin
         rd_val = now.hour;
      end else if (idx == IDX_AHOUR) begin
         rd_val = k.alarm.hour;
      end else if (idx == IDX_WDAY) begin
         rd_val = k.cal.wday;
      end else if (idx == IDX_DATE) begin
         rd_val = k.cal.date;
      end else if (idx == IDX_MONTH) begin
         rd_val = k.cal.month;
      end else if (idx == IDX_RATE) begin
         rd_val = {s.update_in_progress, 3'h0, k.rate};
      end else if (idx == IDX_CMD) begin
         rd_val = {k.set, s.periodic_irq_enable, s.alarm_irq_enable, s.update_end_irq_enable, 1'b0,
                   k.mode.bin, k.mode.h24, k.mode.dst_en};
      end else if (idx == IDX_FLAG) begin
         rd_val = {s.irq, s.pf, s.af, s.uf, 4'h0};
      end else if (idx == IDX_VALID) begin
         rd_val = {k.ram_valid, 7'h00};
      end
   end

   // ==========================================================
   // control side, cleared by the bus reset
   always_comb begin
      next_s     = s;
      next_s.ack = take;
      // data is caught on the first edge so the clear cannot alter it
      if (take) begin
         next_s.rdata = rd_val;
         next_s.rep   = {s.pf, s.af, s.uf};
      end
      next_s.div = base ? 12'h000 : s.div + 12'h001;
      if (base) begin
         next_s.phase = s.phase + PHASE_W'(1);
      end
      next_s.upd = sec_tick;
      // update in progress drops once set is seen
      next_s.update_in_progress = ~k.set & (s.phase > UIP_FROM);
      // only flags that were reported are cleared; a new event wins
      next_s.uf = (s.uf & ~(clr & s.rep[0])) | s.upd;
      next_s.af = (s.af & ~(clr & s.rep[1])) | (s.upd & alarm_hit);
      next_s.pf = (s.pf & ~(clr & s.rep[2])) | pf_hit;
      if (done_wr && idx == IDX_CMD) begin
         next_s.periodic_irq_enable = wd[CMD_PIE];
         next_s.alarm_irq_enable = wd[CMD_AIE];
         next_s.update_end_irq_enable = wd[CMD_UIE] & ~(wd[CMD_SET] & ~k.set);
      end
      next_s.irq = (next_s.pf & next_s.periodic_irq_enable) | (next_s.af & next_s.alarm_irq_enable)
                 | (next_s.uf & next_s.update_end_irq_enable);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // battery side: formats, set, rate, alarm, calendar, ram valid
   always_comb begin
      next_k         = k;
      next_k.ps_meta = power_sense_in;
      next_k.ps_sync = k.ps_meta;
      if (done_wr) begin
         if (idx == IDX_ASEC) begin
            next_k.alarm.sec = wd;
         end else if (idx == IDX_AMIN) begin
            next_k.alarm.min = wd;
         end else if (idx == IDX_AHOUR) begin
            next_k.alarm.hour = wd;
         end else if (idx == IDX_WDAY) begin
            next_k.cal.wday = wd;
         end else if (idx == IDX_DATE) begin
            next_k.cal.date = wd;
         end else if (idx == IDX_MONTH) begin
            next_k.cal.month = wd;
         end else if (idx == IDX_RATE) begin
            next_k.rate = wd[3:0];
         end else if (idx == IDX_CMD) begin
            next_k.mode.dst_en = wd[CMD_DST];
            next_k.mode.h24    = wd[CMD_H24];
            next_k.mode.bin    = wd[CMD_BIN];
            next_k.set         = wd[CMD_SET];
         end
      end
      if (done_rd && idx == IDX_VALID) begin
         next_k.ram_valid = 1'b1;
      end
      // lost power sense overrides a marking read
      if (!k.ps_sync) begin
         next_k.ram_valid = 1'b0;
      end
   end

   // no reset: these survive the bus reset
   always_ff @(posedge clk) begin
      k <= next_k;
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_irq_pin;
      clock_irq_n == !((s.pf & s.periodic_irq_enable) | (s.af & s.alarm_irq_enable) | (s.uf & s.update_end_irq_enable));
   endproperty
   a_irq_pin: assert property (p_irq_pin)
      else $error("interrupt pin disagrees with flags and enables");

   property p_flag_clear;
      (clr && s.rep[0] && !s.upd) |=> !s.uf && clock_irq_n || s.pf || s.af;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("update flag survived a flag read");

   property p_alarm_cause;
      $rose(s.af) |-> $past(s.upd);
   endproperty
   a_alarm_cause: assert property (p_alarm_cause)
      else $error("alarm flag rose without an update");

   property p_pf_set;
      pf_hit |=> s.pf;
   endproperty
   a_pf_set: assert property (p_pf_set)
      else $error("periodic flag missed a tap edge");

   property p_uie_drop;
      (done_wr && idx == IDX_CMD && wd[CMD_SET] && !k.set) |=> !s.update_end_irq_enable;
   endproperty
   a_uie_drop: assert property (p_uie_drop)
      else $error("update enable kept while set rose");

   property p_uip_off;
      k.set |=> !s.update_in_progress;
   endproperty
   a_uip_off: assert property (p_uip_off)
      else $error("update in progress shown while set");

   property p_valid_low;
      !k.ps_sync |=> !k.ram_valid;
   endproperty
   a_valid_low: assert property (p_valid_low)
      else $error("ram valid high with power sense low");

   property p_valid_rise;
      $rose(k.ram_valid) |-> $past(done_rd && idx == IDX_VALID);
   endproperty
   a_valid_rise: assert property (p_valid_rise)
      else $error("ram valid set without a validity read");

   property p_rsv_zero;
      (take && bus_req.read && idx == IDX_FLAG) |=> readdata[3:0] == 4'h0 && !waitrequest;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("flag read returned reserved bits or stalled");

   // set wins: an event in the clearing cycle keeps its flag
   property p_uf_set;
      s.upd |=> s.uf;
   endproperty
   a_uf_set: assert property (p_uf_set)
      else $error("update flag missed an update");

   property p_af_set;
      (s.upd && alarm_hit) |=> s.af;
   endproperty
   a_af_set: assert property (p_af_set)
      else $error("alarm flag missed a match");

   // a reported periodic flag goes once no new tap edge arrives with the clear
   property p_pf_clear;
      (clr && s.rep[2] && !pf_hit) |=> !s.pf;
   endproperty
   a_pf_clear: assert property (p_pf_clear)
      else $error("periodic flag survived a flag read");

   // the first edge after the bus reset sees enables and flags cleared
   property p_reset_clear;
      $rose(resetn) |-> !s.update_end_irq_enable && !s.alarm_irq_enable && !s.periodic_irq_enable && !s.uf && !s.af && !s.pf && !s.irq;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("bus reset left an enable or flag set");

   property p_rdata_hold;
      (take && bus_req.read && idx == IDX_FLAG) |=>
         readdata[6] == $past(s.pf) && readdata[5] == $past(s.af)
         && readdata[4] == $past(s.uf);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("flag read returned values altered by its own clear");

   property p_cmd_rsv;
      (take && bus_req.read && idx == IDX_CMD) |=> !readdata[3];
   endproperty
   a_cmd_rsv: assert property (p_cmd_rsv)
      else $error("reserved command bit read as one");

   property p_valid_rsv;
      (take && bus_req.read && idx == IDX_VALID) |=> readdata[6:0] == 7'h00;
   endproperty
   a_valid_rsv: assert property (p_valid_rsv)
      else $error("validity register returned nonzero low bits");

   c_irq: cover property (!clock_irq_n);
   c_update: cover property (s.upd);
   c_valid_set: cover property (done_rd && idx == IDX_VALID && k.ps_sync);
   c_flag_clear: cover property (clr && s.rep != 3'h0);
   c_alarm: cover property (s.upd && alarm_hit);

endmodule

//--- design/rtc_pkg.sv
package rtc_pkg;

   // ==========================================================
   // timing
   localparam int CLK_HZ         = 100_000_000;
   localparam int BASE_HZ        = 32_768;
   localparam int BASE_DIV       = CLK_HZ / BASE_HZ;
   localparam int PHASE_W        = 15;
   localparam int UIP_LEAD_US    = 244;
   localparam int UIP_LEAD_TICKS = (UIP_LEAD_US * BASE_HZ + 999_999) / 1_000_000;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [3:0] IDX_SEC   = 4'h0;
   localparam logic [3:0] IDX_ASEC  = 4'h1;
   localparam logic [3:0] IDX_MIN   = 4'h2;
   localparam logic [3:0] IDX_AMIN  = 4'h3;
   localparam logic [3:0] IDX_HOUR  = 4'h4;
   localparam logic [3:0] IDX_AHOUR = 4'h5;
   localparam logic [3:0] IDX_WDAY  = 4'h6;
   localparam logic [3:0] IDX_DATE  = 4'h7;
   localparam logic [3:0] IDX_MONTH = 4'h8;
   localparam logic [3:0] IDX_RATE  = 4'hA;
   localparam logic [3:0] IDX_CMD   = 4'hB;
   localparam logic [3:0] IDX_FLAG  = 4'hC;
   localparam logic [3:0] IDX_VALID = 4'hD;

   // ==========================================================
   // command bit positions
   localparam int CMD_DST = 0;
   localparam int CMD_H24 = 1;
   localparam int CMD_BIN = 2;
   localparam int CMD_UIE = 4;
   localparam int CMD_AIE = 5;
   localparam int CMD_PIE = 6;
   localparam int CMD_SET = 7;

   // ==========================================================
   // time codes, bcd and binary
   localparam logic [7:0] SEC_LAST_BCD = 8'h59;
   localparam logic [7:0] SEC_LAST_BIN = 8'h3B;
   localparam logic [7:0] H24_LAST_BCD = 8'h23;
   localparam logic [7:0] H24_LAST_BIN = 8'h17;
   localparam logic [7:0] H12_TOP_BCD  = 8'h12;
   localparam logic [7:0] H12_TOP_BIN  = 8'h0C;
   localparam logic [7:0] HOUR_ONE     = 8'h01;
   localparam logic [7:0] HOUR_THREE   = 8'h03;
   localparam logic [7:0] MONTH_APRIL  = 8'h04;
   localparam logic [7:0] OCT_BCD      = 8'h10;
   localparam logic [7:0] OCT_BIN      = 8'h0A;
   localparam logic [7:0] DAY_SUNDAY   = 8'h01;
   localparam logic [7:0] LAST_WK_BCD  = 8'h25;
   localparam logic [7:0] LAST_WK_BIN  = 8'h19;
   localparam logic [1:0] ALARM_WILD   = 2'h3;
   localparam logic [3:0] RS_SLOW_OFS  = 4'h6;
   localparam logic [3:0] RS_FAST_MIN  = 4'h3;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avalon_req_s;

   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
   } clock_time_s;

   typedef struct packed {
      logic [7:0] wday;
      logic [7:0] date;
      logic [7:0] month;
   } calendar_s;

   typedef struct packed {
      logic dst_en;
      logic h24;
      logic bin;
   } time_mode_s;

endpackage

//--- design/rtc_time_keeper.sv
`timescale 1ns/100ps
module rtc_time_keeper
   import rtc_pkg::*;
(
   // clock and second enable
   input  wire logic        clk,
   input  wire logic        tick,
   // formats and calendar
   input  wire time_mode_s  mode,
   input  wire calendar_s   cal,
   // software write port
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_sel,
   input  wire logic [7:0]  wr_data,
   // current time
   output clock_time_s      now
);

   // battery side: time survives the bus reset, so no reset here
   typedef struct packed {
      clock_time_s t;
      logic        dst_done;
   } keep_s;

   keep_s s;
   keep_s next_s;
   logic [7:0] sl;
   logic       at159;
   logic       last_sun;
   logic       oct;

   // ==========================================================
   // counting helpers
   function automatic logic [7:0] bump(input logic [7:0] v, input logic bin);
      if (bin || v[3:0] != 4'h9) begin
         return v + 8'h01;
      end
      return {v[7:4] + 4'h1, 4'h0};
   endfunction

   function automatic logic [7:0] next_hour(input logic [7:0] h, input time_mode_s m);
      logic [7:0] top;
      logic [7:0] nh;
      top = m.bin ? H12_TOP_BIN : H12_TOP_BCD;
      if (m.h24) begin
         return (h == (m.bin ? H24_LAST_BIN : H24_LAST_BCD)) ? 8'h00 : bump(h, m.bin);
      end
      if ({1'b0, h[6:0]} == top) begin
         return {h[7], 7'h01};
      end
      nh = bump({1'b0, h[6:0]}, m.bin);
      // 11 to 12 flips the pm bit
      return {h[7] ^ (nh == top), nh[6:0]};
   endfunction

   // ==========================================================
   // one second step with the two summer time exceptions
   always_comb begin
      next_s   = s;
      sl       = mode.bin ? SEC_LAST_BIN : SEC_LAST_BCD;
      at159    = s.t.hour == HOUR_ONE && s.t.min == sl && s.t.sec == sl;
      last_sun = cal.wday == DAY_SUNDAY && cal.date >= (mode.bin ? LAST_WK_BIN : LAST_WK_BCD);
      oct      = cal.month == (mode.bin ? OCT_BIN : OCT_BCD);
      if (wr_en) begin
         if (wr_sel == 2'h0) begin
            next_s.t.sec = wr_data;
         end else if (wr_sel == 2'h1) begin
            next_s.t.min = wr_data;
         end else begin
            next_s.t.hour   = wr_data;
            next_s.dst_done = 1'b0;
         end
      end else if (tick) begin
         if (mode.dst_en && at159 && last_sun && cal.month == MONTH_APRIL) begin
            next_s.t = {8'h00, 8'h00, HOUR_THREE};
            next_s.t.hour = HOUR_THREE;
            next_s.t.min  = 8'h00;
            next_s.t.sec  = 8'h00;
         end else if (mode.dst_en && at159 && last_sun && oct && !s.dst_done) begin
            next_s.t.hour   = HOUR_ONE;
            next_s.t.min    = 8'h00;
            next_s.t.sec    = 8'h00;
            next_s.dst_done = 1'b1;
         end else if (s.t.sec != sl) begin
            next_s.t.sec = bump(s.t.sec, mode.bin);
         end else begin
            next_s.t.sec = 8'h00;
            if (s.t.min != sl) begin
               next_s.t.min = bump(s.t.min, mode.bin);
            end else begin
               next_s.t.min  = 8'h00;
               next_s.t.hour = next_hour(s.t.hour, mode);
            end
         end
         // fall-back memory lasts only for that sunday
         if (!(last_sun && oct)) begin
            next_s.dst_done = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign now = s.t;

endmodule

//--- verification/rtc_host_model.sv
`timescale 1ns/100ps
module rtc_host_model
   import rtc_pkg::*;
(
   // clock
   input  wire logic        clk,
   // avalon-mm master side
   output avalon_req_s      req,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   // ==========================================================
   // bus idle from time zero
   initial begin
      req = '0;
   end

   // one transfer: raised after an edge, held until waitrequest is seen low
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      req.read       <= ~wr;
      req.write      <= wr;
      req.address    <= a;
      req.writedata  <= {24'h00_0000, d};
      req.byteenable <= 4'hF;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata[7:0];
      // stale write data is inverted so a lingering value never passes
      req.read      <= 1'b0;
      req.write     <= 1'b0;
      req.writedata <= ~req.writedata;
      @(posedge clk);
   endtask
endmodule

//--- verification/test_rtc_control_status_interrupt.sv
`timescale 1ns/100ps
module test_rtc_control_status_interrupt
   import rtc_pkg::*;
;
   // ==========================================================
   // design signals
   logic        clk;
   logic        resetn;
   logic        power_sense_in;
   avalon_req_s bus_req;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        clock_irq_n;
   int          n_fail     = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   logic [7:0]  cmd_m;
   logic [7:0]  q;
   logic [7:0]  v;
   logic [5:0]  adr [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20};
   logic [7:0]  dat [9] = '{8'h59, 8'hC0, 8'h10, 8'hFF, 8'h05, 8'hD5, 8'h02, 8'h10, 8'h06};

   // one-cycle time base keeps a second at 32768 cycles
   rtc_control_status_interrupt #(.TB_DIV(1)) i_rtc_control_status_interrupt (
      .clk(clk), .resetn(resetn), .bus_req(bus_req), .readdata(readdata),
      .waitrequest(waitrequest), .power_sense_in(power_sense_in), .clock_irq_n(clock_irq_n));
   rtc_host_model i_rtc_host_model (
      .clk(clk), .req(bus_req), .readdata(readdata), .waitrequest(waitrequest));

   // ==========================================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // writes to the command register also update the command model: bit 3 drops, set rising clears update enable
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] nv;
      i_rtc_host_model.xfer(1'b1, a, d, q);
      nv = d & 8'hF7;
      if (nv[7] && !cmd_m[7])
         nv[4] = 1'b0;
      if (a == 6'h2C)
         cmd_m = nv;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      i_rtc_host_model.xfer(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), q, exp);
   endtask

   // sampled mid-cycle where the pin has settled, then back on the rising edge
   task automatic pin(input logic exp);
      @(negedge clk);
      chk("irq pin", {7'h00, clock_irq_n}, {7'h00, exp});
      @(posedge clk);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      resetn = 1'b0;
      power_sense_in = 1'b1;
      cmd_m = 8'h00;
      v = $urandom(20);
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // battery side starts unknown: define set and rate, then a bus reset
      // clears the flags that the unknown rate may have left unknown
      wr(6'h2C, 8'h80);
      wr(6'h28, 8'h00);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(6'h2C, cmd_m);
      wr(6'h2C, 8'hFF);
      rd(6'h2C, cmd_m);
      wr(6'h30, 8'hFF);
      rd(6'h30, 8'h00);
      rd(6'h24, 8'h00);
      rd(6'h28, 8'h00);
      // periodic flag sets while its enable is off, then drives the pin
      wr(6'h2C, 8'h80);
      wr(6'h28, 8'h03);
      repeat (10) @(posedge clk);
      rd(6'h30, 8'h40);
      pin(1'b1);
      wr(6'h2C, 8'hC0);
      repeat (3) @(posedge clk);
      pin(1'b0);
      rd(6'h30, 8'hC0);
      wr(6'h28, 8'h00);
      i_rtc_host_model.xfer(1'b0, 6'h30, 8'h00, q);
      rd(6'h30, 8'h00);
      pin(1'b1);
      // one full second: update and wildcard alarm both raise the pin
      wr(6'h2C, 8'h82);
      for (int i = 0; i < 9; i++)
         wr(adr[i], dat[i]);
      i_rtc_host_model.xfer(1'b0, 6'h30, 8'h00, q);
      wr(6'h2C, 8'h32);
      for (int i = 0; i < 34000 && clock_irq_n !== 1'b0; i++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      rd(6'h30, 8'hB0);
      rd(6'h00, 8'h00);
      rd(6'h08, 8'h11);
      wr(6'h2C, 8'hB2);
      rd(6'h2C, cmd_m);
      // ram valid is set by its own read and lost while power sense is low
      i_rtc_host_model.xfer(1'b0, 6'h34, 8'h00, q);
      rd(6'h34, 8'h80);
      wr(6'h34, 8'hFF);
      rd(6'h34, 8'h80);
      power_sense_in <= 1'b0;
      repeat (5) @(posedge clk);
      rd(6'h34, 8'h00);
      power_sense_in <= 1'b1;
      repeat (5) @(posedge clk);
      rd(6'h34, 8'h00);
      rd(6'h34, 8'h80);
      // mid-run reset clears the enables but keeps set, formats and ram valid
      wr(6'h2C, 8'hF0 | (v & 8'h07));
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      cmd_m = cmd_m & 8'h8F;
      rd(6'h2C, cmd_m);
      rd(6'h34, 8'h80);
      rd(6'h30, 8'h00);
      wrap_up();
   end
endmodule
